// ==== hw/cfsr_regs.sv ====
// charger fault status registers and event flags, register port side
`timescale 1ns/1ps
`include "cfsr_defs.svh"
module cfsr_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port from the serial control engine
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic wack_q,
  // live protection conditions from the analog side
  input wire cfsr_pkg::cfsr_fault_a_type fault_a_in,
  input wire cfsr_pkg::cfsr_fault_b_type fault_b_in,
  // status lines that raise event flags
  input wire cfsr_pkg::cfsr_event_src_type event_src_in
);

  logic rst_meta_q;
  logic rst_n_q;
  logic [`CFSR_COND_WIDTH-1:0] cond_s;
  cfsr_pkg::cfsr_fault_a_type fault_a_s;
  cfsr_pkg::cfsr_fault_b_type fault_b_s;
  cfsr_pkg::cfsr_event_src_type src_s;
  cfsr_pkg::cfsr_event_src_type src_prev_q;
  logic [7:0] fault_a_word;
  logic [7:0] fault_b_word;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] flag_set;
  logic rd_flags;

  // byte for a register offset; unmapped offsets read zero
  function automatic logic [7:0] reg_value(
    input logic [7:0] a,
    input logic [7:0] fa,
    input logic [7:0] fb,
    input logic [7:0] fl
  );
    logic [7:0] v;
    v = `CFSR_READ_ZERO;
    case (a)
      `CFSR_OFS_FAULT_A: v = fa;
      `CFSR_OFS_FAULT_B: v = fb;
      `CFSR_OFS_FLAGS_A: v = fl;
      default: v = `CFSR_READ_ZERO;
    endcase
    return v;
  endfunction : reg_value

  // reset release through two flops, assertion is still immediate
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // every analog level crosses two flops before any logic looks at it
  cfsr_sync #(
    .WIDTH(`CFSR_COND_WIDTH)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n_q),
    .async_d({fault_a_in, fault_b_in, event_src_in}),
    .sync_q(cond_s)
  );

  assign {fault_a_s, fault_b_s, src_s} = cond_s;

  // status bytes follow the live conditions, nothing latched
  assign fault_a_word = fault_a_s;
  // reserved bits 3, 1 and 0 tied low
  assign fault_b_word = {fault_b_s.system_rail_short,
                         fault_b_s.system_rail_overvoltage,
                         fault_b_s.reverse_supply_overvoltage,
                         fault_b_s.reverse_supply_undervoltage,
                         1'b0,
                         fault_b_s.thermal_shutdown_active,
                         2'b00};

  // previous level of each event source for edge detection
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_s;
    end
  end

  // limit, watchdog and weak source on rise; the rest on any change
  always_comb begin
    flag_set = 8'h00;
    flag_set[`CFSR_FLG_ICL] = src_s.input_current_limit &
                              ~src_prev_q.input_current_limit;
    flag_set[`CFSR_FLG_VCL] = src_s.input_voltage_limit &
                              ~src_prev_q.input_voltage_limit;
    flag_set[`CFSR_FLG_WDG] = src_s.watchdog_expired &
                              ~src_prev_q.watchdog_expired;
    flag_set[`CFSR_FLG_WEAK] = src_s.weak_source &
                               ~src_prev_q.weak_source;
    flag_set[`CFSR_FLG_PG] = src_s.power_good ^
                             src_prev_q.power_good;
    flag_set[`CFSR_FLG_AC2] = src_s.second_input_present ^
                              src_prev_q.second_input_present;
    flag_set[`CFSR_FLG_AC1] = src_s.first_input_present ^
                              src_prev_q.first_input_present;
    flag_set[`CFSR_FLG_BUS] = src_s.bus_present ^
                              src_prev_q.bus_present;
  end

  assign rd_flags = rd_en && (addr == `CFSR_OFS_FLAGS_A);

  // clear on read, but a new event in the same cycle survives it
  assign flags_d = rd_flags ? flag_set : (flags_q | flag_set);

  // sticky event flags; writes never reach them
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= `CFSR_RESET_VALUE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // read data captured at the read strobe, held until the next read
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= `CFSR_RESET_VALUE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (rd_en) begin
        rdata_q <= reg_value(addr, fault_a_word, fault_b_word, flags_q);
      end
    end
  end

  // writes are acknowledged and dropped; data is deliberately unused
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wack_q <= 1'b0;
    end else begin
      wack_q <= wr_en && (wdata == wdata);
    end
  end

  a_read_fault_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_en && addr == `CFSR_OFS_FAULT_A |=>
      rvalid_q && rdata_q == $past(cond_s[20:13]))
    else $error("fault a read mismatch");

  a_read_fault_b: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_en && addr == `CFSR_OFS_FAULT_B |=>
      rdata_q[3] == 1'b0 && rdata_q[1:0] == 2'b00 &&
      rdata_q[7:4] == $past(cond_s[12:9]) && rdata_q[2] == $past(cond_s[8]))
    else $error("fault b read mismatch");

  a_read_unmapped: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_en && addr != `CFSR_OFS_FAULT_A && addr != `CFSR_OFS_FAULT_B &&
      addr != `CFSR_OFS_FLAGS_A |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");

  a_flag_rise_set: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $rose(src_s.input_current_limit) |=> flags_q[7])
    else $error("limit flag missed a rise");

  a_flag_pg_change: assert property (@(posedge mclk) disable iff (!rst_n_q)
    src_s.power_good != $past(src_s.power_good) |=> flags_q[3])
    else $error("power good flag missed a change");

  a_flag_presence: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $changed(src_s.bus_present) ##1 !rd_flags [*2] |=> flags_q[0])
    else $error("presence flag not held");

  a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n_q)
    !rd_flags |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without read");

  a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_flags && flag_set == 8'h00 |=> flags_q == 8'h00 &&
      rdata_q == $past(flags_q))
    else $error("flag read did not clear");

  a_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n_q)
    wr_en && !rd_en && flag_set == 8'h00 |=> $stable(flags_q) &&
      $stable(rdata_q) && wack_q)
    else $error("write changed state");

  a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rvalid_q && !$past(rd_en, 1) |-> 1'b0)
    else $error("read valid without read");

  // a clearing read must never swallow an event of the same cycle
  a_flag_set_wins: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_flags |=> (flags_q & $past(flag_set)) == $past(flag_set))
    else $error("event lost to clearing read");

  a_flag_vcl_rise: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $rose(src_s.input_voltage_limit) |=> flags_q[6])
    else $error("voltage limit flag missed a rise");

  a_flag_wdg_rise: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $rose(src_s.watchdog_expired) |=> flags_q[5])
    else $error("watchdog flag missed a rise");

  a_flag_weak_rise: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $rose(src_s.weak_source) |=> flags_q[4])
    else $error("weak source flag missed a rise");

  // the weak source flag stays quiet when its source drops
  a_flag_no_fall: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $fell(src_s.weak_source) && !flags_q[4] |=> !flags_q[4])
    else $error("weak source flag set on a fall");

  a_flag_ac2_change: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $changed(src_s.second_input_present) |=> flags_q[2])
    else $error("second input flag missed a change");

  a_flag_ac1_change: assert property (@(posedge mclk) disable iff (!rst_n_q)
    $changed(src_s.first_input_present) |=> flags_q[1])
    else $error("first input flag missed a change");

  a_read_answer: assert property (@(posedge mclk) disable iff (!rst_n_q)
    rd_en |=> rvalid_q)
    else $error("read not answered");

  a_write_answer: assert property (@(posedge mclk) disable iff (!rst_n_q)
    wr_en |=> wack_q)
    else $error("write not acknowledged");

endmodule : cfsr_regs

// ==== hw/cfsr_defs.svh ====
// offsets, field positions and reset values of the fault status bank
`ifndef CFSR_DEFS_SVH
`define CFSR_DEFS_SVH

`define CFSR_OFS_FAULT_A 8'h20
`define CFSR_OFS_FAULT_B 8'h21
`define CFSR_OFS_FLAGS_A 8'h22
`define CFSR_RESET_VALUE 8'h00
`define CFSR_READ_ZERO 8'h00

// event flag bit positions
`define CFSR_FLG_ICL 7
`define CFSR_FLG_VCL 6
`define CFSR_FLG_WDG 5
`define CFSR_FLG_WEAK 4
`define CFSR_FLG_PG 3
`define CFSR_FLG_AC2 2
`define CFSR_FLG_AC1 1
`define CFSR_FLG_BUS 0

// width of the synchronised condition vector
`define CFSR_COND_WIDTH 21

`endif

// ==== hw/cfsr_pkg.sv ====
// types of the charger fault status bank
package cfsr_pkg;

  // live fault conditions, first register order
  typedef struct packed {
    logic battery_discharge_limit_active;
    logic bus_input_overvoltage;
    logic battery_overvoltage;
    logic bus_input_overcurrent;
    logic battery_overcurrent;
    logic converter_overcurrent;
    logic second_input_overvoltage;
    logic first_input_overvoltage;
  } cfsr_fault_a_type;

  // live fault conditions of the second register
  typedef struct packed {
    logic system_rail_short;
    logic system_rail_overvoltage;
    logic reverse_supply_overvoltage;
    logic reverse_supply_undervoltage;
    logic thermal_shutdown_active;
  } cfsr_fault_b_type;

  // status lines whose changes raise event flags
  typedef struct packed {
    logic input_current_limit;
    logic input_voltage_limit;
    logic watchdog_expired;
    logic weak_source;
    logic power_good;
    logic second_input_present;
    logic first_input_present;
    logic bus_present;
  } cfsr_event_src_type;

endpackage : cfsr_pkg

// ==== hw/cfsr_sync.sv ====
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module cfsr_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // asynchronous levels in, synchronised out
  input wire logic [WIDTH-1:0] async_d,
  output logic [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_d;
      sync_q <= meta_q;
    end
  end

endmodule : cfsr_sync

// ==== sim/cfsr_host.sv ====
// host model issuing reads and writes on the register port
`timescale 1ns/1ps
module cfsr_host (
  // clock
  input wire logic mclk,
  // register port towards the bank
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic wack_q
);
  // idle request lines at time zero
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // one read; the strobe drops once the answer is seen
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    n = 0;
    @(negedge mclk);
    rd_en = 1'b1;
    addr = a;
    do begin
      @(negedge mclk);
      n++;
    end while (rvalid_q !== 1'b1 && n < 4);
    ok = (rvalid_q === 1'b1);
    d = rdata_q;
    rd_en = 1'b0;
    addr = ~a; // released lines never keep the old value
  endtask : rd

  // one write, bounded wait for the acknowledge
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    output logic ok);
    int n;
    n = 0;
    @(negedge mclk);
    wr_en = 1'b1;
    addr = a;
    wdata = v;
    do begin
      @(negedge mclk);
      n++;
    end while (wack_q !== 1'b1 && n < 4);
    ok = (wack_q === 1'b1);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask : wr
endmodule : cfsr_host

// ==== sim/tb.sv ====
// self-checking bench for the charger fault status bank
`timescale 1ns/1ps
module tb;
  logic mclk, rst_b, rd_en, wr_en, rvalid_q, wack_q, ok;
  logic [7:0] addr, wdata, rdata_q, d, e;
  cfsr_pkg::cfsr_fault_a_type fa;
  cfsr_pkg::cfsr_fault_b_type fb;
  cfsr_pkg::cfsr_event_src_type ev;
  int fail_count = 0;
  int checks_done = 0;

  cfsr_regs uut (.mclk(mclk), .rst_b(rst_b), .rd_en(rd_en),
    .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .wack_q(wack_q), .fault_a_in(fa),
    .fault_b_in(fb), .event_src_in(ev));
  cfsr_host host (.mclk(mclk), .rd_en(rd_en), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .wack_q(wack_q));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // read one offset, expect an answer and a value
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, x);
  endtask : rdc

  // two sync flops plus edge detect need a few cycles
  task automatic settle();
    repeat (4) @(negedge mclk);
  endtask : settle

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // cut a hang short, far beyond the expected run
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    fa = 8'h00;
    fb = 5'h00;
    ev = 8'h00;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    rdc(8'h20, 8'h00);
    rdc(8'h21, 8'h00);
    rdc(8'h22, 8'h00);
    $display("test reset values done");
    // walking one; the previous bit must be gone again
    for (int i = 0; i < 8; i++) begin
      fa = 8'h01 << i;
      settle();
      rdc(8'h20, 8'h01 << i);
    end
    for (int i = 0; i < 5; i++) begin
      fb = 5'h01 << i;
      e = {fb[4:1], 1'b0, fb[0], 2'b00};
      settle();
      rdc(8'h21, e);
    end
    fb = 5'h1f;
    settle();
    rdc(8'h21, 8'hf4);
    $display("test live status done");
    // rise sets every flag; fall sets only change-type flags
    for (int i = 0; i < 8; i++) begin
      ev = 8'h01 << i;
      settle();
      rdc(8'h22, 8'h01 << i);
      rdc(8'h22, 8'h00);
      ev = 8'h00;
      settle();
      rdc(8'h22, (i < 4) ? 8'h01 << i : 8'h00);
    end
    $display("test event flags done");
    fa = 8'h5a;
    ev = 8'h80;
    settle();
    host.wr(8'h20, 8'hff, ok);
    chk({7'h00, ok}, 8'h01);
    host.wr(8'h22, 8'h00, ok);
    chk({7'h00, ok}, 8'h01);
    rdc(8'h20, 8'h5a);
    rdc(8'h22, 8'h80);
    rdc(8'h23, 8'h00);
    $display("test writes ignored done");
    conclude();
  end
endmodule : tb
